/* hdl/rscw_loader.sv */
`timescale 1ns/100ps
// Behaviour
// [RULE_01] hold a 20-bit word, D19 down to D0, all writable serially
// [RULE_02] desense code zero means no desensitisation
// [RULE_03] bandwidth code zero selects 1712 Hz demodulator bandwidth
// [RULE_04] slice code both ones sets fifty percent slicer threshold
// [RULE_05] check code D8=1, D7=0 requires four consecutive valid windows
// [RULE_06] window code D11..D9 = 011 selects a 433 us window
// [RULE_07] sleep code D14..D12 = 100 sleeps 160 ms between checks
// [RULE_08] D15 set enables autopoll, alternating bit check and sleep
// [RULE_09] D16 clear keeps normal demodulator bandwidth
// [RULE_10] D18 set keeps the watchdog disabled
// [RULE_11] D19 clear applies no signal-strength offset
// [RULE_12] start in shutdown with defaults loaded; host holds shutdown high
// [RULE_13] host drops shutdown after initialisation to start operation
// [RULE_14] clock high releases data pin; start is clock and data pulses
// [RULE_15] host shifts MSB first from any bit down to D0
// [RULE_16] data low-high-low under high clock, then clock low, ends it
// [RULE_17] host keeps clock high and low phases above 0.1 us
// [RULE_18] sample data on each rising clock, apply word only at stop
// [RULE_19] autopoll holds data low while sleeping, passes data after check
module rscw_loader #(
    parameter int SLEEP_UNIT_CYC = rscw_pkg::SLEEP_UNIT_CYC
) (
    // system
    input wire logic clock,
    input wire logic rst,
    // serial link
    input wire logic serial_clock,
    input wire logic data_pin_i,
    output logic data_pin_o,
    output logic data_pin_oe,
    // power control
    input wire logic power_down_pin,
    // receiver side
    input wire logic rx_data,
    input wire logic window_ok,
    input wire logic window_bad,
    // configuration and status
    output rscw_pkg::rscw_cfg_t cfg,
    output rscw_pkg::rscw_mode_t mode,
    output logic receiver_awake,
    output logic prog_active
);

    localparam int TRI_LIM = 3;
    // shutdown reads as asserted until the synchroniser has filled
    localparam logic [rscw_pkg::SYNC_W-1:0] SY_RESET =
        rscw_pkg::SYNC_W'(1'b1) << rscw_pkg::SY_PD;

    typedef struct packed {
        logic [rscw_pkg::SYNC_W-1:0] sy1;
        logic [rscw_pkg::SYNC_W-1:0] sy2;
        logic [rscw_pkg::SYNC_W-1:0] prev;
        rscw_pkg::rscw_link_st_t st;
        rscw_pkg::rscw_cfg_t cfg;
        rscw_pkg::rscw_mode_t mode;
        logic [rscw_pkg::WORD_W-1:0] shift;
        logic [rscw_pkg::CNT_W-1:0] cnt;
        logic dout;
        logic oe;
    } rscw_main_t;

    rscw_main_t s;
    rscw_main_t next_s;
    logic sampled_bit;
    logic pass_data;
    logic sclk;
    logic sclk_up;
    logic sclk_dn;
    logic dat_up;
    logic dat_dn;
    logic dat;
    logic pd;
    logic [rscw_pkg::WORD_W-1:0] mask;
    logic [rscw_pkg::WORD_W-1:0] merged;

    function automatic rscw_pkg::rscw_mode_t decode(
        input rscw_pkg::rscw_cfg_t c
    );
        rscw_pkg::rscw_mode_t m;
        m.desense_off = (c.desense_code == rscw_pkg::DESENSE_NONE); // RULE_02
        m.bw_1712 = (c.bw_code == rscw_pkg::BW_1712); // RULE_03
        m.slice_half = (c.slice_code == rscw_pkg::SLICE_HALF); // RULE_04
        m.check_four = (c.check_code == rscw_pkg::CHECK_FOUR); // RULE_05
        m.window_433 = (c.window_code == rscw_pkg::WINDOW_433); // RULE_06
        m.sleep_160 = (c.sleep_code == rscw_pkg::SLEEP_160); // RULE_07
        m.autopoll_en = c.autopoll; // RULE_08
        m.normal_bw = !c.high_bw; // RULE_09
        m.watchdog_en = !c.watchdog_off; // RULE_10
        m.rssi_offset_en = c.rssi_offset; // RULE_11
        return m;
    endfunction : decode

    rscw_link_sampler u_link (
        .serial_clock(serial_clock),
        .data_pin_i(data_pin_i),
        .sampled_bit(sampled_bit)
    );

    rscw_poll #(
        .SLEEP_UNIT_CYC(SLEEP_UNIT_CYC)
    ) u_poll (
        .clock(clock),
        .rst(rst),
        .autopoll_en(s.cfg.autopoll),
        .check_code(s.cfg.check_code),
        .sleep_code(s.cfg.sleep_code),
        .window_ok(window_ok),
        .window_bad(window_bad),
        .awake(receiver_awake),
        .pass_data(pass_data)
    );

    // edges are seen on the second stage only
    assign sclk = s.sy2[rscw_pkg::SY_SCLK];
    assign sclk_up = sclk && !s.prev[rscw_pkg::SY_SCLK];
    assign sclk_dn = !sclk && s.prev[rscw_pkg::SY_SCLK];
    assign dat = s.sy2[rscw_pkg::SY_DATA];
    assign dat_up = dat && !s.prev[rscw_pkg::SY_DATA];
    assign dat_dn = !dat && s.prev[rscw_pkg::SY_DATA];
    assign pd = s.sy2[rscw_pkg::SY_PD];

    // bits above the shifted count keep their old value
    assign mask = (s.cnt >= rscw_pkg::CNT_FULL) ? '1 :
        ((20'h00001 << s.cnt) - 20'h00001); // RULE_01
    assign merged = (s.cfg & ~mask) | (s.shift & mask);

    always_comb
    begin
        next_s = s;
        next_s.sy1 = {rx_data, power_down_pin, data_pin_i, serial_clock};
        next_s.sy2 = s.sy1;
        next_s.prev = s.sy2;
        case (s.st)
            rscw_pkg::ST_RUN:
            begin
                if (sclk)
                begin
                    next_s.st = rscw_pkg::ST_REL; // RULE_14
                end
            end
            rscw_pkg::ST_REL:
            begin
                // host must already hold data low when the clock drops
                if (sclk_dn)
                begin
                    next_s.st = dat ? rscw_pkg::ST_RUN : rscw_pkg::ST_ARM;
                end
            end
            rscw_pkg::ST_ARM:
            begin
                if (dat_up)
                begin
                    next_s.st = rscw_pkg::ST_RUN;
                end
                else if (sclk_up)
                begin
                    next_s.st = rscw_pkg::ST_SYNC; // RULE_14
                end
            end
            rscw_pkg::ST_SYNC:
            begin
                if (sclk_dn)
                begin
                    next_s.st = rscw_pkg::ST_RUN;
                end
                else if (dat_up)
                begin
                    next_s.st = rscw_pkg::ST_MARK;
                end
            end
            rscw_pkg::ST_MARK:
            begin
                if (sclk_dn)
                begin
                    next_s.st = rscw_pkg::ST_RUN;
                end
                else if (dat_dn)
                begin
                    next_s.st = rscw_pkg::ST_PROG; // RULE_14
                    next_s.cnt = '0;
                end
            end
            rscw_pkg::ST_PROG:
            begin
                if (sclk_up)
                begin
                    next_s.shift = {s.shift[rscw_pkg::WORD_W-2:0],
                        sampled_bit}; // RULE_18
                    if (s.cnt != rscw_pkg::CNT_FULL)
                    begin
                        next_s.cnt = s.cnt + 5'h01;
                    end
                end
                else if (sclk && dat_up)
                begin
                    next_s.st = rscw_pkg::ST_STOP1; // RULE_16
                end
            end
            rscw_pkg::ST_STOP1:
            begin
                // clock falling here was a bit, not a stop
                if (sclk_dn)
                begin
                    next_s.st = rscw_pkg::ST_PROG;
                end
                else if (dat_dn)
                begin
                    next_s.st = rscw_pkg::ST_STOP2;
                end
            end
            rscw_pkg::ST_STOP2:
            begin
                if (sclk_dn)
                begin
                    next_s.cfg = merged; // RULE_18
                    next_s.st = rscw_pkg::ST_RUN; // RULE_16
                end
                else if (dat_up)
                begin
                    next_s.st = rscw_pkg::ST_STOP1;
                end
            end
            default:
            begin
                next_s.st = rscw_pkg::ST_RUN;
            end
        endcase
        // shutdown drops any half-done frame and keeps the word
        if (pd)
        begin
            next_s.st = rscw_pkg::ST_RUN; // RULE_12
        end
        next_s.oe = (next_s.st == rscw_pkg::ST_RUN) && !sclk && !pd; // RULE_14
        next_s.dout = pass_data && s.sy2[rscw_pkg::SY_RX]; // RULE_19
        next_s.mode = decode(next_s.cfg);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s <= '{sy1: SY_RESET, sy2: SY_RESET, prev: SY_RESET,
                st: rscw_pkg::ST_RUN, cfg: rscw_pkg::CTL_RESET,
                mode: decode(rscw_pkg::CTL_RESET),
                shift: '0, cnt: '0, dout: 1'b0, oe: 1'b0}; // RULE_12
        end
        else
        begin
            s <= next_s;
        end
    end

    assign data_pin_o = s.dout;
    assign data_pin_oe = s.oe;
    assign cfg = s.cfg;
    assign mode = s.mode;
    assign prog_active = (s.st != rscw_pkg::ST_RUN);

    property p_word_only_at_stop;
        @(posedge clock) disable iff (rst)
        s.cfg != $past(s.cfg) |-> $past(s.st) == rscw_pkg::ST_STOP2;
    endproperty
    a_word_only_at_stop: assert property (p_word_only_at_stop) // RULE_18
        else $error("word changed outside a stop sequence");

    property p_apply_merge;
        @(posedge clock) disable iff (rst)
        s.st == rscw_pkg::ST_STOP2 && sclk_dn && !pd
            |=> s.cfg == $past(merged) && s.st == rscw_pkg::ST_RUN;
    endproperty
    a_apply_merge: assert property (p_apply_merge) // RULE_01
        else $error("stop did not apply the shifted bits");

    property p_release_on_clock;
        @(posedge clock) disable iff (rst)
        $rose(s.sy2[rscw_pkg::SY_SCLK]) |-> ##[1:TRI_LIM] !data_pin_oe;
    endproperty
    a_release_on_clock: assert property (p_release_on_clock) // RULE_14
        else $error("data pin still driven after clock rose");

    property p_restore_after_stop;
        @(posedge clock) disable iff (rst)
        s.st == rscw_pkg::ST_STOP2 && sclk_dn && !pd
            |=> data_pin_oe;
    endproperty
    a_restore_after_stop: assert property (p_restore_after_stop) // RULE_16
        else $error("data pin not returned to output after stop");

    property p_sample_rise;
        @(posedge clock) disable iff (rst)
        s.st == rscw_pkg::ST_PROG && sclk_up && !pd
            |=> s.shift[0] == $past(sampled_bit);
    endproperty
    a_sample_rise: assert property (p_sample_rise) // RULE_18
        else $error("rising clock did not shift the data bit");

    property p_shutdown_quiet;
        @(posedge clock) disable iff (rst)
        pd |=> !data_pin_oe && s.st == rscw_pkg::ST_RUN;
    endproperty
    a_shutdown_quiet: assert property (p_shutdown_quiet) // RULE_12
        else $error("link active during shutdown");

    property p_mode_tracks;
        @(posedge clock) disable iff (rst)
        $changed(s.cfg) |-> mode.desense_off ==
            (cfg.desense_code == rscw_pkg::DESENSE_NONE)
            && mode.bw_1712 == (cfg.bw_code == rscw_pkg::BW_1712)
            && mode.slice_half == (cfg.slice_code == rscw_pkg::SLICE_HALF);
    endproperty
    a_mode_tracks: assert property (p_mode_tracks) // RULE_02
        else $error("decoded mode lags the word");

    property p_flags;
        @(posedge clock) disable iff (rst)
        mode.watchdog_en != cfg.watchdog_off
            && mode.normal_bw != cfg.high_bw
            && mode.rssi_offset_en == cfg.rssi_offset;
    endproperty
    a_flags: assert property (p_flags) // RULE_10
        else $error("watchdog, bandwidth or offset flag wrong");

    property p_sleep_low;
        @(posedge clock) disable iff (rst)
        !pass_data |=> !data_pin_o;
    endproperty
    a_sleep_low: assert property (p_sleep_low) // RULE_19
        else $error("data pin not low while polling");

    c_start: cover property (@(posedge clock) disable iff (rst)
        $rose(s.st == rscw_pkg::ST_PROG));
    c_apply: cover property (@(posedge clock) disable iff (rst)
        s.st == rscw_pkg::ST_STOP2 ##1 s.st == rscw_pkg::ST_RUN);
    c_full: cover property (@(posedge clock) disable iff (rst)
        s.cnt == rscw_pkg::CNT_FULL && s.st == rscw_pkg::ST_STOP2);

endmodule : rscw_loader

/* shared/rscw_pkg.sv */
package rscw_pkg;

    // control word geometry
    localparam int WORD_W = 20;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h14;
    localparam logic [WORD_W-1:0] CTL_RESET = 20'h00000;

    // clock and timing
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int TRI_MAX_NS = 100;
    localparam int TRI_MAX_CYC = TRI_MAX_NS * (SYS_CLK_HZ / 1_000_000) / 1000;
    localparam int SLEEP_UNIT_MS = 10;
    localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_MS * (SYS_CLK_HZ / 1000);
    localparam int SLEEP_CNT_W = 27;

    // field codes with documented meaning
    localparam logic [2:0] DESENSE_NONE = 3'h0;
    localparam logic [1:0] BW_1712 = 2'h0;
    localparam logic [1:0] SLICE_HALF = 2'h3;
    localparam logic [1:0] CHECK_FOUR = 2'h2;
    localparam logic [2:0] WINDOW_433 = 3'h3;
    localparam logic [2:0] SLEEP_160 = 3'h4;

    // synchroniser lanes
    localparam int SYNC_W = 4;
    localparam int SY_SCLK = 0;
    localparam int SY_DATA = 1;
    localparam int SY_PD = 2;
    localparam int SY_RX = 3;

    // word layout, most significant bit first
    typedef struct packed {
        logic rssi_offset;
        logic watchdog_off;
        logic spare;
        logic high_bw;
        logic autopoll;
        logic [2:0] sleep_code;
        logic [2:0] window_code;
        logic [1:0] check_code;
        logic [1:0] slice_code;
        logic [1:0] bw_code;
        logic [2:0] desense_code;
    } rscw_cfg_t;

    typedef struct packed {
        logic desense_off;
        logic bw_1712;
        logic slice_half;
        logic check_four;
        logic window_433;
        logic sleep_160;
        logic autopoll_en;
        logic normal_bw;
        logic watchdog_en;
        logic rssi_offset_en;
    } rscw_mode_t;

    typedef enum logic [7:0] {
        ST_RUN = 8'h01,
        ST_REL = 8'h02,
        ST_ARM = 8'h04,
        ST_SYNC = 8'h08,
        ST_MARK = 8'h10,
        ST_PROG = 8'h20,
        ST_STOP1 = 8'h40,
        ST_STOP2 = 8'h80
    } rscw_link_st_t;

    typedef enum logic [3:0] {
        P_OFF = 4'h1,
        P_SLEEP = 4'h2,
        P_CHECK = 4'h4,
        P_PASS = 4'h8
    } rscw_poll_st_t;

endpackage : rscw_pkg

/* hdl/rscw_link_sampler.sv */
`timescale 1ns/100ps
module rscw_link_sampler (
    // link side
    input wire logic serial_clock,
    input wire logic data_pin_i,
    // system side, read only after a synchronised rise
    output logic sampled_bit
);

    typedef struct packed {
        logic bit_val;
    } rscw_lk_t;

    rscw_lk_t s;
    rscw_lk_t next_s;

    // no reset: the clock may stand still, and the bit is only read
    // after the system side has seen the edge that wrote it
    always_comb
    begin
        next_s = s;
        next_s.bit_val = data_pin_i; // RULE_18
    end

    always_ff @(posedge serial_clock)
    begin
        s <= next_s;
    end

    assign sampled_bit = s.bit_val;

endmodule : rscw_link_sampler

/* hdl/rscw_poll.sv */
`timescale 1ns/100ps
module rscw_poll #(
    parameter int SLEEP_UNIT_CYC = rscw_pkg::SLEEP_UNIT_CYC
) (
    // system
    input wire logic clock,
    input wire logic rst,
    // configuration
    input wire logic autopoll_en,
    input wire logic [1:0] check_code,
    input wire logic [2:0] sleep_code,
    // window verdicts from the demodulator
    input wire logic window_ok,
    input wire logic window_bad,
    // status
    output logic awake,
    output logic pass_data
);

    typedef struct packed {
        rscw_pkg::rscw_poll_st_t ps;
        logic [rscw_pkg::SLEEP_CNT_W-1:0] cnt;
        logic [3:0] hits;
        logic awake;
        logic pass;
    } rscw_poll_t;

    rscw_poll_t s;
    rscw_poll_t next_s;
    logic [rscw_pkg::SLEEP_CNT_W-1:0] sleep_load;
    logic [3:0] need;

    assign sleep_load = (rscw_pkg::SLEEP_CNT_W'(SLEEP_UNIT_CYC) << sleep_code)
        - 27'h0000001; // RULE_07
    assign need = 4'h1 << check_code; // RULE_05

    always_comb
    begin
        next_s = s;
        case (s.ps)
            rscw_pkg::P_OFF:
            begin
                if (autopoll_en)
                begin
                    next_s.ps = rscw_pkg::P_SLEEP; // RULE_08
                    next_s.cnt = sleep_load;
                end
            end
            rscw_pkg::P_SLEEP:
            begin
                if (s.cnt == '0)
                begin
                    next_s.ps = rscw_pkg::P_CHECK;
                    next_s.hits = 4'h0;
                end
                else
                begin
                    next_s.cnt = s.cnt - 27'h0000001;
                end
            end
            rscw_pkg::P_CHECK:
            begin
                // a bad window restarts the whole sleep period
                if (window_bad)
                begin
                    next_s.ps = rscw_pkg::P_SLEEP; // RULE_08
                    next_s.cnt = sleep_load;
                end
                else if (window_ok)
                begin
                    next_s.hits = s.hits + 4'h1;
                    if (s.hits + 4'h1 == need)
                    begin
                        next_s.ps = rscw_pkg::P_PASS; // RULE_19
                    end
                end
            end
            rscw_pkg::P_PASS:
            begin
                next_s.ps = rscw_pkg::P_PASS;
            end
            default:
            begin
                next_s.ps = rscw_pkg::P_OFF;
            end
        endcase
        if (!autopoll_en)
        begin
            next_s.ps = rscw_pkg::P_OFF;
        end
        next_s.awake = (next_s.ps != rscw_pkg::P_SLEEP);
        next_s.pass = (next_s.ps == rscw_pkg::P_OFF) ||
            (next_s.ps == rscw_pkg::P_PASS); // RULE_19
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s <= '{ps: rscw_pkg::P_OFF, cnt: '0, hits: 4'h0,
                awake: 1'b1, pass: 1'b1};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign awake = s.awake;
    assign pass_data = s.pass;

    property p_sleep_quiet;
        @(posedge clock) disable iff (rst)
        s.ps == rscw_pkg::P_SLEEP |-> !pass_data && !awake;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) // RULE_19
        else $error("data passed or awake while sleeping");

    property p_sleep_ends;
        @(posedge clock) disable iff (rst)
        autopoll_en && s.ps == rscw_pkg::P_SLEEP && s.cnt == '0
            |=> s.ps == rscw_pkg::P_CHECK || s.ps == rscw_pkg::P_OFF;
    endproperty
    a_sleep_ends: assert property (p_sleep_ends) // RULE_08
        else $error("sleep did not hand over to bit check");

    property p_pass_after_check;
        @(posedge clock) disable iff (rst)
        autopoll_en && $rose(pass_data) |->
            $past(s.ps) == rscw_pkg::P_CHECK && $past(s.hits) + 4'h1 == need;
    endproperty
    a_pass_after_check: assert property (p_pass_after_check) // RULE_05
        else $error("data released without enough valid windows");

    c_pass: cover property (@(posedge clock) disable iff (rst)
        autopoll_en && $rose(pass_data));

endmodule : rscw_poll

/* verification/rscw_host.sv */
`timescale 1ns/100ps
module rscw_host (
    // link toward the loader
    output logic serial_clock,
    output logic host_data,
    output logic host_drive
);
    logic tick = 1'b0;

    // 6 ns timebase; the clock pin itself only moves inside frames
    initial
    begin
        forever #3 tick = ~tick;
    end

    initial
    begin
        serial_clock = 1'b0;
        host_data = 1'b0;
        host_drive = 1'b0;
    end

    // 34 ticks keep every phase above 0.1 us and 8 system clocks
    task automatic phase(input logic c, input logic d, input logic en);
        serial_clock = c;
        host_data = d;
        host_drive = en;
        repeat (34) @(posedge tick);
    endtask : phase

    task automatic start_frame;
        phase(1'b1, 1'b0, 1'b0);
        phase(1'b1, 1'b0, 1'b1);
        phase(1'b0, 1'b0, 1'b1);
        phase(1'b1, 1'b0, 1'b1);
        phase(1'b1, 1'b1, 1'b1);
        phase(1'b1, 1'b0, 1'b1);
    endtask : start_frame

    task automatic send_bits(input logic [19:0] w, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            phase(1'b0, w[i], 1'b1);
            phase(1'b1, w[i], 1'b1);
        end
    endtask : send_bits

    // released wire falls to the pull-down level with the clock
    task automatic idle;
        phase(1'b0, 1'b0, 1'b0);
    endtask : idle

    // data first goes low, so a last bit of one still gives a rising edge
    task automatic stop_frame;
        phase(1'b1, 1'b0, 1'b1);
        phase(1'b1, 1'b1, 1'b1);
        phase(1'b1, 1'b0, 1'b1);
        idle();
    endtask : stop_frame
endmodule : rscw_host

/* verification/tb_top.sv */
`timescale 1ns/100ps
`define CHK(what, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("BAD %s exp %h got %h", what, exp, got); \
        end \
    end

module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic power_down_pin = 1'b1;
    logic rx_data = 1'b0;
    logic window_ok = 1'b0;
    logic window_bad = 1'b0;
    logic serial_clock;
    logic host_data;
    logic host_drive;
    logic data_pin_i;
    logic data_pin_o;
    logic data_pin_oe;
    logic receiver_awake;
    logic prog_active;
    rscw_pkg::rscw_cfg_t cfg;
    rscw_pkg::rscw_mode_t mode;
    int err_count = 0;
    int checks = 0;

    initial
    begin
        forever #12.5 clock = ~clock;
    end

    // pull-down holds the wire low when nobody drives it
    assign data_pin_i = data_pin_oe ? data_pin_o :
                        (host_drive ? host_data : 1'b0);

    rscw_host host (
        .serial_clock(serial_clock),
        .host_data(host_data),
        .host_drive(host_drive)
    );

    rscw_loader #(.SLEEP_UNIT_CYC(8)) dut (
        .clock(clock),
        .rst(rst),
        .serial_clock(serial_clock),
        .data_pin_i(data_pin_i),
        .data_pin_o(data_pin_o),
        .data_pin_oe(data_pin_oe),
        .power_down_pin(power_down_pin),
        .rx_data(rx_data),
        .window_ok(window_ok),
        .window_bad(window_bad),
        .cfg(cfg),
        .mode(mode),
        .receiver_awake(receiver_awake),
        .prog_active(prog_active)
    );

    task automatic give_verdict;
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic write_word(input logic [19:0] w, input int n,
                              input logic [19:0] exp_cfg);
        rscw_pkg::rscw_cfg_t old;
        old = cfg;
        host.start_frame();
        `CHK("oe in frame", 1'b0, data_pin_oe)
        `CHK("prog", 1'b1, prog_active)
        host.send_bits(w, n);
        `CHK("cfg before stop", old, cfg)
        host.stop_frame();
        `CHK("oe after stop", 1'b1, data_pin_oe)
        `CHK("prog", 1'b0, prog_active)
        `CHK("cfg", exp_cfg, cfg)
    endtask : write_word

    task automatic pulse(input logic bad);
        @(negedge clock);
        window_bad = bad;
        window_ok = ~bad;
        @(negedge clock);
        window_bad = 1'b0;
        window_ok = 1'b0;
    endtask : pulse

    // sleep length in cycles, bounded wait for the wake-up
    task automatic sleep_len(input int lo, input int hi);
        int n;
        n = 0;
        while (receiver_awake !== 1'b1 && n < 400)
        begin
            @(negedge clock);
            n++;
        end
        if (n >= 400)
        begin
            err_count++;
            give_verdict();
        end
        else
        begin
            `CHK("sleep", 1'b1, n >= lo && n <= hi)
        end
    endtask : sleep_len

    initial
    begin
        repeat (12) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        `CHK("cfg reset", rscw_pkg::CTL_RESET, cfg)
        `CHK("oe reset", 1'b0, data_pin_oe)
        `CHK("awake reset", 1'b1, receiver_awake)
        host.start_frame();
        `CHK("oe shutdown", 1'b0, data_pin_oe)
        host.idle();
        @(negedge clock);
        power_down_pin = 1'b0;
        repeat (8) @(negedge clock);
        write_word(20'hFFFFF, 20, 20'hFFFFF);
        `CHK("mode", 10'h089, mode)
        write_word(20'h00002, 3, 20'hFFFFA);
        write_word(20'h00000, 20, 20'h00000);
        `CHK("mode", 10'h306, mode)
        host.start_frame();
        host.send_bits(20'hFFFFF, 10);
        @(negedge clock);
        power_down_pin = 1'b1;
        repeat (8) @(negedge clock);
        `CHK("oe abort", 1'b0, data_pin_oe)
        host.idle();
        `CHK("cfg abort", 20'h00000, cfg)
        @(negedge clock);
        power_down_pin = 1'b0;
        rx_data = 1'b1;
        repeat (8) @(negedge clock);
        write_word(20'h4C760, 20, 20'h4C760);
        `CHK("mode", 10'h3FC, mode)
        `CHK("awake", 1'b0, receiver_awake)
        `CHK("data sleeping", 1'b0, data_pin_o)
        sleep_len(118, 128);
        pulse(1'b1);
        @(negedge clock);
        `CHK("awake after bad", 1'b0, receiver_awake)
        sleep_len(124, 131);
        repeat (3) pulse(1'b0);
        repeat (3) @(negedge clock);
        `CHK("data checking", 1'b0, data_pin_o)
        pulse(1'b0);
        repeat (3) @(negedge clock);
        `CHK("data passing", 1'b1, data_pin_o)
        `CHK("awake passing", 1'b1, receiver_awake)
        give_verdict();
    end
endmodule : tb_top
